// File: hw/dsa_aligner.sv
// Converter end: splits the sample bus into four quadrants and re-samples
// them on the chosen clock cycle, watching drift and resynchronising.
// Assumes the pump runs on the same clock and delivers one word a cycle.
`timescale 1ns/10ps
module dsa_aligner
  import dsa_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  dsa_link_if.device link,
  output logic [WORD_W-1:0] sampleOut,
  output logic sampleValid,
  output logic [1:0] currentQuadrant,
  output logic alignAlarm
);
  dsaDevState_t r;
  dsaDevState_t next_r;

  logic manualEff;
  logic extEff;
  logic portOpen;
  logic accWr;
  logic accRd;
  logic [1:0] rdIdx;
  logic [1:0] age;
  logic warn;
  logic pinUpdate;
  logic doUpdate;
  logic [1:0] optimal;

  always_comb begin
    manualEff = r.manual | link.portDisablePin;
    extEff = r.extEn & manualEff;
    portOpen = ~link.portDisablePin & ~link.chipSelN;
    accWr = portOpen & link.regWr;
    accRd = portOpen & link.regRd;
    rdIdx = r.sampleCnt + r.quadrant;
    age = r.wrPtr - rdIdx;
    // Age zero means the channel is being rewritten: phase slipped past a cycle
    warn = (r.mode == DSA_LOCKED) && (age == WARN_AGE);
    pinUpdate = link.portDisablePin & link.updatePin & ~r.updPinQ;
    doUpdate = ((r.mode == DSA_INIT) & link.busValid)
      | r.updReq
      | pinUpdate
      | (~manualEff & r.alarm);
    optimal = r.wrPtr - OPTIMAL_AGE - r.sampleCnt;
  end

  always_comb begin
    next_r = r;
    next_r.sampleCnt = r.sampleCnt + 2'h1;
    next_r.updPinQ = link.updatePin;
    if (link.busValid) begin
      next_r.chan[r.wrPtr] = link.busWord;
      next_r.wrPtr = r.wrPtr + 2'h1;
    end
    next_r.sampleOut = r.chan[rdIdx];
    next_r.sampleValid = (r.mode == DSA_LOCKED);
    if (doUpdate) begin
      next_r.mode = DSA_LOCKED;
      // Switching quadrant skips or repeats the words between old and new
      next_r.quadrant = extEff ? r.forced : optimal;
      next_r.updReq = 1'b0;
      next_r.alarm = 1'b0;
    end else begin
      next_r.alarm = r.alarm | warn;
    end
    if (accWr) begin
      case (link.regAddr)
        ADDR_PORT_CFG: begin
          next_r.threeWire = link.regWdata[BIT_THREE_WIRE];
        end
        ADDR_ALIGN_CTRL: begin
          next_r.manual = link.regWdata[BIT_MANUAL];
          if (link.regWdata[BIT_UPDATE]) begin
            next_r.updReq = 1'b1;
          end
        end
        ADDR_QUAD_CFG: begin
          next_r.extEn = link.regWdata[BIT_EXT];
          next_r.forced = link.regWdata[FORCED_HI:FORCED_LO];
        end
        default: begin
          next_r.threeWire = r.threeWire;
        end
      endcase
    end
    next_r.rdata = '0;
    if (accRd) begin
      case (link.regAddr)
        ADDR_PORT_CFG: begin
          next_r.rdata[BIT_THREE_WIRE] = r.threeWire;
        end
        ADDR_ALIGN_CTRL: begin
          next_r.rdata[BIT_MANUAL] = r.manual;
          next_r.rdata[BIT_UPDATE] = r.updReq;
          next_r.rdata[BIT_ALARM] = r.alarm;
        end
        ADDR_QUAD_STAT: begin
          next_r.rdata[QUAD_HI:QUAD_LO] = r.quadrant;
        end
        ADDR_QUAD_CFG: begin
          next_r.rdata[BIT_EXT] = r.extEn;
          next_r.rdata[FORCED_HI:FORCED_LO] = r.forced;
        end
        default: begin
          next_r.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r.mode <= DSA_INIT;
      r.wrPtr <= '0;
      r.sampleCnt <= '0;
      r.chan <= '0;
      r.quadrant <= QUAD_RESET;
      r.manual <= 1'b0;
      r.extEn <= 1'b0;
      r.forced <= QUAD_RESET;
      r.threeWire <= 1'b0;
      r.updReq <= 1'b0;
      r.alarm <= 1'b0;
      r.updPinQ <= 1'b0;
      r.rdata <= '0;
      r.sampleOut <= '0;
      r.sampleValid <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    link.regRdata = r.rdata;
    link.alarmPinOut = link.portDisablePin & r.alarm;
    // Pin is driven only as alarm output, or as a 4-wire data pin while selected
    link.alarmPinOeN = ~(link.portDisablePin
      | (~link.chipSelN & ~r.threeWire));
    sampleOut = r.sampleOut;
    sampleValid = r.sampleValid;
    currentQuadrant = r.quadrant;
    alignAlarm = r.alarm;
  end
endmodule : dsa_aligner

// File: hw/dsa_link_if.sv
// Link between the data pump and the converter aligner.
// Assumes both ends share one clock; the pump resolves the output pin from its enable.
`timescale 1ns/10ps
interface dsa_link_if;
  import dsa_pkg::*;
  logic [WORD_W-1:0] busWord;
  logic busValid;
  logic [ADDR_W-1:0] regAddr;
  logic [REG_W-1:0] regWdata;
  logic regWr;
  logic regRd;
  logic [REG_W-1:0] regRdata;
  logic chipSelN;
  logic portDisablePin;
  logic updatePin;
  logic alarmPinOut;
  logic alarmPinOeN;

  modport device (
    input busWord, busValid, regAddr, regWdata, regWr, regRd, chipSelN,
    input portDisablePin, updatePin,
    output regRdata, alarmPinOut, alarmPinOeN
  );
  modport host (
    output busWord, busValid, regAddr, regWdata, regWr, regRd, chipSelN,
    output portDisablePin, updatePin,
    input regRdata, alarmPinOut, alarmPinOeN
  );
endinterface : dsa_link_if

// File: hw/dsa_pkg.sv
// Constants and state types shared by both ends of the data sync aligner.
// Assumes one 50 MHz clock for the converter end and the data pump end.
package dsa_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 8;
  localparam int REG_W = 8;
  localparam int NUM_QUAD = 4;

  // Converter-side register offsets and field positions
  localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
  localparam logic [7:0] ADDR_ALIGN_CTRL = 8'h02;
  localparam logic [7:0] ADDR_QUAD_STAT = 8'h15;
  localparam logic [7:0] ADDR_QUAD_CFG = 8'h16;
  localparam int BIT_THREE_WIRE = 7;
  localparam int BIT_ALARM = 0;
  localparam int BIT_UPDATE = 1;
  localparam int BIT_MANUAL = 7;
  localparam int BIT_EXT = 5;
  localparam int FORCED_LO = 3;
  localparam int FORCED_HI = 4;
  localparam int QUAD_LO = 0;
  localparam int QUAD_HI = 1;
  localparam logic [1:0] QUAD_RESET = 2'h0;
  localparam logic [1:0] OPTIMAL_AGE = 2'h2;
  localparam logic [1:0] WARN_AGE = 2'h0;

  // Pump-side user register offsets and field positions
  localparam logic [7:0] ADDR_HOST_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HOST_STAT = 8'h01;
  localparam int HC_MANUAL = 0;
  localparam int HC_EXT = 1;
  localparam int HC_FORCED_LO = 2;
  localparam int HC_FORCED_HI = 3;
  localparam int HC_PORT_DIS = 4;
  localparam int HC_TIE_PINS = 5;
  localparam int HC_THREE_WIRE = 6;
  localparam int HC_UPDATE = 7;
  localparam int HS_ALARM = 0;
  localparam int HS_QUAD_LO = 1;
  localparam int HS_QUAD_HI = 2;
  localparam int HS_PENDING = 3;

  typedef enum logic [1:0] {
    DSA_INIT = 2'b01,
    DSA_LOCKED = 2'b10
  } dsaDevMode_t;

  typedef enum logic [3:0] {
    DSA_POLL_CTRL = 4'b0001,
    DSA_POLL_QUAD = 4'b0010,
    DSA_WR_CTRL = 4'b0100,
    DSA_WR_QUAD = 4'b1000
  } dsaHostMode_t;

  typedef struct packed {
    dsaDevMode_t mode;
    logic [1:0] wrPtr;
    logic [1:0] sampleCnt;
    logic [NUM_QUAD-1:0][WORD_W-1:0] chan;
    logic [1:0] quadrant;
    logic manual;
    logic extEn;
    logic [1:0] forced;
    logic threeWire;
    logic updReq;
    logic alarm;
    logic updPinQ;
    logic [REG_W-1:0] rdata;
    logic [WORD_W-1:0] sampleOut;
    logic sampleValid;
  } dsaDevState_t;

  typedef struct packed {
    dsaHostMode_t mode;
    logic manual;
    logic extEn;
    logic [1:0] forced;
    logic portDis;
    logic tiePins;
    logic threeWire;
    logic updPend;
    logic pendCtrl;
    logic pendQuad;
    logic alarm;
    logic [1:0] quadrant;
    logic [1:0] lastRd;
    logic [REG_W-1:0] busRdata;
    logic [WORD_W-1:0] busWord;
    logic busValid;
    logic [ADDR_W-1:0] regAddr;
    logic [REG_W-1:0] regWdata;
    logic regWr;
    logic regRd;
    logic updPin;
    logic [REG_W-1:0] userRdata;
  } dsaHostState_t;
endpackage : dsa_pkg

// File: hw/dsa_pump.sv
// Data pump end: drives the sample bus and runs the aligner controls,
// either over register accesses or over the two pins with the port off.
// Assumes the same clock as the converter end; user port is a plain port.
`timescale 1ns/10ps
module dsa_pump
  import dsa_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  dsa_link_if.host link,
  input wire logic [WORD_W-1:0] userWord,
  input wire logic userValid,
  input wire logic [ADDR_W-1:0] userAddr,
  input wire logic [REG_W-1:0] userWdata,
  input wire logic userWr,
  input wire logic userRd,
  output logic [REG_W-1:0] userRdata
);
  dsaHostState_t r;
  dsaHostState_t next_r;
  logic pinAlarm;

  always_comb begin
    pinAlarm = ~link.alarmPinOeN & link.alarmPinOut;
    next_r = r;
    next_r.busWord = userWord;
    next_r.busValid = userValid;
    next_r.regWr = 1'b0;
    next_r.regRd = 1'b0;
    // Read data arrive the cycle after the strobe, so tag the read of last cycle
    next_r.lastRd[1] = r.regRd & ~r.portDis & (r.regAddr == ADDR_QUAD_STAT);
    next_r.lastRd[0] = r.regRd & ~r.portDis & (r.regAddr == ADDR_ALIGN_CTRL);
    if (r.portDis) begin
      next_r.alarm = pinAlarm;
      next_r.updPin = r.tiePins ? pinAlarm : r.updPend;
      if (r.updPin && !r.tiePins) begin
        next_r.updPend = 1'b0;
      end
      next_r.mode = DSA_POLL_CTRL;
    end else begin
      next_r.updPin = 1'b0;
      if (r.lastRd[0]) begin
        next_r.alarm = link.regRdata[BIT_ALARM];
      end
      if (r.lastRd[1]) begin
        next_r.quadrant = link.regRdata[QUAD_HI:QUAD_LO];
      end
      // Quadrant config goes first so that an update uses the new value
      if (r.pendQuad) begin
        next_r.mode = DSA_WR_QUAD;
        next_r.pendQuad = 1'b0;
        next_r.regWr = 1'b1;
        next_r.regAddr = ADDR_QUAD_CFG;
        next_r.regWdata = '0;
        next_r.regWdata[BIT_EXT] = r.extEn & r.manual;
        next_r.regWdata[FORCED_HI:FORCED_LO] = r.forced;
      end else if (r.pendCtrl || (r.manual && r.alarm)) begin
        next_r.mode = DSA_WR_CTRL;
        next_r.pendCtrl = 1'b0;
        next_r.regWr = 1'b1;
        next_r.regAddr = ADDR_ALIGN_CTRL;
        next_r.regWdata = '0;
        next_r.regWdata[BIT_MANUAL] = r.manual;
        next_r.regWdata[BIT_UPDATE] = r.updPend | (r.manual & r.alarm);
        next_r.updPend = 1'b0;
        next_r.alarm = 1'b0;
      end else if (r.mode == DSA_WR_CTRL) begin
        // Port mode follows each control write; polling resumes with the control read
        next_r.mode = DSA_POLL_QUAD;
        next_r.regWr = 1'b1;
        next_r.regAddr = ADDR_PORT_CFG;
        next_r.regWdata = '0;
        next_r.regWdata[BIT_THREE_WIRE] = r.threeWire;
      end else if (r.mode == DSA_POLL_CTRL) begin
        next_r.mode = DSA_POLL_QUAD;
        next_r.regRd = 1'b1;
        next_r.regAddr = ADDR_QUAD_STAT;
      end else begin
        next_r.mode = DSA_POLL_CTRL;
        next_r.regRd = 1'b1;
        next_r.regAddr = ADDR_ALIGN_CTRL;
      end
    end
    // A user write lands after the link logic so that a new request is never lost
    if (userWr && userAddr == ADDR_HOST_CTRL) begin
      next_r.manual = userWdata[HC_MANUAL];
      next_r.extEn = userWdata[HC_EXT];
      next_r.forced = userWdata[HC_FORCED_HI:HC_FORCED_LO];
      next_r.portDis = userWdata[HC_PORT_DIS];
      next_r.tiePins = userWdata[HC_TIE_PINS];
      next_r.threeWire = userWdata[HC_THREE_WIRE];
      next_r.updPend = next_r.updPend | userWdata[HC_UPDATE];
      next_r.pendCtrl = 1'b1;
      next_r.pendQuad = 1'b1;
    end
    next_r.userRdata = '0;
    if (userRd && userAddr == ADDR_HOST_CTRL) begin
      next_r.userRdata[HC_MANUAL] = r.manual;
      next_r.userRdata[HC_EXT] = r.extEn;
      next_r.userRdata[HC_FORCED_HI:HC_FORCED_LO] = r.forced;
      next_r.userRdata[HC_PORT_DIS] = r.portDis;
      next_r.userRdata[HC_TIE_PINS] = r.tiePins;
      next_r.userRdata[HC_THREE_WIRE] = r.threeWire;
    end else if (userRd && userAddr == ADDR_HOST_STAT) begin
      next_r.userRdata[HS_ALARM] = r.alarm;
      next_r.userRdata[HS_QUAD_HI:HS_QUAD_LO] = r.quadrant;
      next_r.userRdata[HS_PENDING] = r.updPend;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.mode <= DSA_POLL_CTRL;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    link.busWord = r.busWord;
    link.busValid = r.busValid;
    link.regAddr = r.regAddr;
    link.regWdata = r.regWdata;
    link.regWr = r.regWr & ~r.portDis;
    link.regRd = r.regRd & ~r.portDis;
    link.chipSelN = ~((r.regWr | r.regRd) & ~r.portDis);
    link.portDisablePin = r.portDis;
    link.updatePin = r.updPin;
    userRdata = r.userRdata;
  end
endmodule : dsa_pump

// File: verification/dsa_link_properties.sv
// Checker for the link between the data pump and the aligner.
// Assumes it sees the link signals on the single shared clock.
`timescale 1ns/10ps
module dsa_link_properties
  import dsa_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [REG_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [REG_W-1:0] regRdata,
  input wire logic chipSelN,
  input wire logic portDisablePin,
  input wire logic alarmPinOeN
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_cs_needs_strobe: assert property (!chipSelN |-> (regWr || regRd))
    else $error("chip select low without a strobe");
  a_one_strobe: assert property (!(regWr && regRd))
    else $error("read and write strobes together");
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
  a_sdo_released: assert property ((chipSelN && $past(chipSelN) && !portDisablePin
    && !$past(portDisablePin)) |-> alarmPinOeN)
    else $error("alarm pin driven while deselected");
  a_pin_drives: assert property ((portDisablePin && $past(portDisablePin))
    |-> !alarmPinOeN)
    else $error("alarm pin not driven with port off");
  a_quad_then_ctrl: assert property ((regWr && regAddr == ADDR_QUAD_CFG)
    |=> (regWr && regAddr == ADDR_ALIGN_CTRL))
    else $error("quadrant setup not followed by control write");
  a_poll_steady: assert property ((regRd && regAddr == ADDR_ALIGN_CTRL)
    |-> ##[1:4] (regRd || regWr || portDisablePin))
    else $error("alarm polling stalled");
  a_alarm_answered: assert property (($past(regRd) && $past(regAddr) == ADDR_ALIGN_CTRL
    && regRdata[BIT_ALARM] && regRdata[BIT_MANUAL])
    |-> ##[1:8] (regWr && regAddr == ADDR_ALIGN_CTRL && regWdata[BIT_UPDATE]))
    else $error("manual alarm not answered by update");
endmodule : dsa_link_properties

// File: verification/tb_top.sv
// Bench joining the data pump to the aligner, driven over the pump user port.
// Assumes one 50 MHz clock; a dropped valid cycle is a one-cycle phase slip.
`timescale 1ns/10ps
module tb_top
  import dsa_pkg::*;
  ;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [WORD_W-1:0] userWord = 16'h0000;
  logic userValid = 1'b1;
  logic [ADDR_W-1:0] userAddr = 8'h00;
  logic [REG_W-1:0] userWdata = 8'h00;
  logic userWr = 1'b0;
  logic userRd = 1'b0;
  logic [REG_W-1:0] userRdata;
  logic [WORD_W-1:0] sampleOut;
  logic sampleValid;
  logic [1:0] currentQuadrant;
  logic alignAlarm;
  // First word reaches the aligner one cycle after its sample counter starts
  logic [1:0] expQ = 2'h3 - OPTIMAL_AGE;
  logic [7:0] st;
  int errors = 0;
  int check_count = 0;
  int hi = 0;
  int hiBase = 0;
  int q;

  dsa_link_if u_dsa_link_if ();
  dsa_aligner u_dsa_aligner (.clock(clock), .rst_n(rst_n), .link(u_dsa_link_if),
    .sampleOut(sampleOut), .sampleValid(sampleValid),
    .currentQuadrant(currentQuadrant), .alignAlarm(alignAlarm));
  dsa_pump u_dsa_pump (.clock(clock), .rst_n(rst_n), .link(u_dsa_link_if),
    .userWord(userWord), .userValid(userValid), .userAddr(userAddr),
    .userWdata(userWdata), .userWr(userWr), .userRd(userRd), .userRdata(userRdata));
  dsa_link_properties u_dsa_link_properties (.clock(clock), .rst_n(rst_n),
    .regAddr(u_dsa_link_if.regAddr), .regWdata(u_dsa_link_if.regWdata),
    .regWr(u_dsa_link_if.regWr), .regRd(u_dsa_link_if.regRd),
    .regRdata(u_dsa_link_if.regRdata), .chipSelN(u_dsa_link_if.chipSelN),
    .portDisablePin(u_dsa_link_if.portDisablePin),
    .alarmPinOeN(u_dsa_link_if.alarmPinOeN));

  always #10 clock = ~clock;
  always @(posedge clock) if (userValid) userWord <= userWord + 16'h0001;
  always @(posedge clock) if (alignAlarm === 1'b1) hi <= hi + 1;

  task print_verdict();
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    userWr <= 1'b1;
    userAddr <= a;
    userWdata <= d;
    @(posedge clock);
    userWr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    userRd <= 1'b1;
    userAddr <= a;
    @(posedge clock);
    userRd <= 1'b0;
    #1 d = userRdata;
  endtask : rd

  // One dropped word moves the best quadrant back by one
  task slip();
    @(posedge clock);
    userValid <= 1'b0;
    @(posedge clock);
    userValid <= 1'b1;
    expQ = expQ - 2'h1;
  endtask : slip

  task waitq(input logic [1:0] w);
    int i;
    #1;
    for (i = 0; i < 40 && currentQuadrant !== w; i++) begin
      @(posedge clock);
      #1;
    end
    chk({14'h0000, currentQuadrant}, {14'h0000, w}, "quadrant");
  endtask : waitq

  task drift();
    hiBase = hi;
    slip();
    repeat (10) @(posedge clock);
    chk(16'(hi - hiBase), 16'h0000, "alarm after one slip");
    slip();
    waitq(expQ);
    repeat (4) @(posedge clock);
  endtask : drift

  task stream(input int n);
    logic [15:0] p;
    int i;
    @(posedge clock);
    #1 p = sampleOut;
    for (i = 0; i < n; i++) begin
      @(posedge clock);
      #1;
      chk(sampleOut, p + 16'h0001, "stream gap");
      p = sampleOut;
    end
  endtask : stream

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    waitq(expQ);
    @(posedge clock);
    #1;
    chk({15'h0000, sampleValid}, 16'h0001, "not aligned");
    stream(20);
    rd(ADDR_HOST_STAT, st);
    chk({14'h0000, st[HS_QUAD_HI:HS_QUAD_LO]}, {14'h0000, expQ}, "status quad");
    drift();
    chk(16'(hi - hiBase), 16'h0001, "auto alarm length");
    stream(20);
    wr(ADDR_HOST_CTRL, 8'h01);
    drift();
    chk({15'h0000, (hi - hiBase) > 1}, 16'h0001, "manual alarm too short");
    for (q = 0; q < 4; q++) begin
      wr(ADDR_HOST_CTRL, 8'h83 | 8'(q << 2));
      waitq(q[1:0]);
      repeat (6) @(posedge clock);
      rd(ADDR_HOST_STAT, st);
      chk({13'h0000, st[HS_PENDING:HS_QUAD_LO]}, {13'h0000, 1'b0, q[1:0]}, "status");
    end
    wr(ADDR_HOST_CTRL, 8'h80);
    waitq(expQ);
    chk({15'h0000, u_dsa_link_if.alarmPinOeN}, 16'h0000, "data pin not driven");
    wr(ADDR_HOST_CTRL, 8'h40);
    repeat (6) @(posedge clock);
    #1;
    chk({15'h0000, u_dsa_link_if.alarmPinOeN}, 16'h0001, "pin driven in three-wire");
    wr(ADDR_HOST_CTRL, 8'h10);
    slip();
    repeat (10) @(posedge clock);
    slip();
    for (q = 0; q < 40 && alignAlarm !== 1'b1; q++) @(posedge clock);
    #1;
    chk({15'h0000, u_dsa_link_if.alarmPinOeN}, 16'h0000, "pin released");
    chk({15'h0000, u_dsa_link_if.alarmPinOut}, 16'h0001, "pin alarm");
    wr(ADDR_HOST_CTRL, 8'h30);
    waitq(expQ);
    print_verdict();
  end
endmodule : tb_top
